/* src/spi_host_controller.sv */
// Operation
// - One serial clock out, one data out, one data in; built when enabled.
// - Host only: every transfer starts here, never from outside.
// - Enable clear: no transfer starts and no interrupt is raised.
// - Clearing enable aborts a running transfer at once.
// - Size field 00/01/10/11 gives 8/16/24/32-bit words.
// - A data write while idle starts one transfer of the written value; data writes during a transfer are ignored.
// - Transmit data comes from the low bits of the written word.
// - Received bits return right-aligned in the data register.
// - Words shift most significant bit first both ways.
// - Eight select outputs, low while their control bit is set.
// - Select lines follow control bits only, independent of transfers.
// - Each finished transfer raises the transfer-done interrupt.
// - Phase picks sample and launch edges; polarity sets idle level.
// - Prescaler picks 2..4096; serial clock is main over twice that.
// - Fast bit ignores prescaler; serial clock is half main clock.
// - Busy flag reads one while a transfer runs.
`timescale 1ns/100ps
`include "spi_host_defs.svh"

module spi_host_controller
    import spi_host_pkg::*;
#(
    parameter bit IMPLEMENT = 1'b1
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [3:0] address,
    input wire logic [31:0] write_data,
    input wire logic write_strobe,
    input wire logic read_strobe,
    output logic [31:0] read_data,
    output logic serial_clock,
    output logic serial_data_out,
    input wire logic serial_data_in,
    output logic [7:0] select_n,
    output logic irq
);
    import spi_host_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchroniser

    logic rst_meta;
    logic rst_n;
    logic sdi_meta;
    logic sdi_sync;
    logic [16:0] control;
    logic [31:0] shift_word;
    logic [5:0] bits_left;
    shift_state_t state;
    logic tick;
    logic done_pulse;
    logic [0:0] irq_status;
    logic [0:0] irq_mask;
    logic sample_bit;
    logic [5:0] total_bits;

    initial begin
        if (!IMPLEMENT) begin
            $error("Controller instantiated while not implemented");
        end
    end

    // Asynchronous assert, synchronous release
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Data input comes from a pin: two flops before use
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sdi_meta <= 1'b0;
            sdi_sync <= 1'b0;
        end else begin
            sdi_meta <= serial_data_in;
            sdi_sync <= sdi_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    // Number of bits in a transfer for a size code
    function automatic logic [5:0] length_bits(input logic [1:0] code);
        logic [5:0] n;
        n = 6'h08;
        case (word_length_t'(code))
            LEN_8: n = 6'h08;
            LEN_16: n = 6'h10;
            LEN_24: n = 6'h18;
            LEN_32: n = 6'h20;
            default: n = 6'h08;
        endcase
        return n;
    endfunction : length_bits

    wire logic enable = control[`CTRL_ENABLE];
    wire logic phase = control[`CTRL_PHASE];
    wire logic polarity = control[`CTRL_POLARITY];
    wire logic busy = (state != ST_IDLE);
    wire logic data_write = write_strobe && (address == `REG_DATA);

    assign total_bits = length_bits(control[`CTRL_SIZE_HI:`CTRL_SIZE_LO]);

    ////////////////////////////////////////////////////////////////////////////
    // Control register

    // Writable fields; changes act at once, software keeps them stable mid-word
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            control <= `CONTROL_RESET;
        end else if (write_strobe && address == `REG_CONTROL) begin
            control <= write_data[`CTRL_WRITABLE_HI:0];
        end
    end

    // Select lines straight from control bits, registered for clean pins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            select_n <= 8'hFF;
        end else begin
            select_n <= ~control[`CTRL_SELECT_HI:`CTRL_SELECT_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial clock timing

    spi_tick_gen #(
        .DIV_WIDTH(13)
    ) u_tick (
        .clk(clk),
        .rst_n(rst_n),
        .run(busy),
        .fast_clock_bit(control[`CTRL_FAST]),
        .clock_divider_select(control[`CTRL_DIV_HI:`CTRL_DIV_LO]),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Shift engine

    // Word aligned so the MSB of the configured length sits at bit 31
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            shift_word <= `WORD_RESET;
            bits_left <= '0;
            sample_bit <= 1'b0;
            done_pulse <= 1'b0;
        end else begin
            done_pulse <= 1'b0;
            if (!enable) begin
                state <= ST_IDLE;
                bits_left <= '0;
            end else begin
                case (state)
                    ST_IDLE: begin
                        if (data_write) begin
                            // Low bits hold the payload; shift it up to the MSB
                            shift_word <= write_data << (6'h20 - total_bits);
                            bits_left <= total_bits;
                            state <= ST_FIRST_HALF;
                        end
                    end
                    ST_FIRST_HALF: begin
                        if (tick) begin
                            // Leading edge: phase 0 samples here
                            if (!phase) begin
                                sample_bit <= sdi_sync;
                            end
                            state <= ST_SECOND_HALF;
                        end
                    end
                    ST_SECOND_HALF: begin
                        if (tick) begin
                            // Trailing edge: phase 0 launches, phase 1 samples
                            shift_word <= {shift_word[30:0], phase ? sdi_sync : sample_bit};
                            bits_left <= bits_left - 1'b1;
                            if (bits_left == 6'h01) begin
                                state <= ST_IDLE;
                                done_pulse <= 1'b1;
                            end else begin
                                state <= ST_FIRST_HALF;
                            end
                        end
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

    // Pins from flops; phase 1 launches on the leading edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_clock <= 1'b0;
            serial_data_out <= 1'b0;
        end else begin
            serial_clock <= polarity ^ (state == ST_SECOND_HALF);
            // Phase 1 launches only with the leading edge, never in the first half
            if (phase && state != ST_SECOND_HALF) begin
                serial_data_out <= serial_data_out;
            end else begin
                serial_data_out <= shift_word[31];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupts

    // Set wins over write-one clear; disabled unit raises nothing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_status <= '0;
            irq_mask <= '0;
        end else begin
            if (write_strobe && address == `REG_IRQ_MASK) begin
                irq_mask <= write_data[`IRQ_DONE_BIT:`IRQ_DONE_BIT];
            end
            if (done_pulse && enable) begin
                irq_status <= 1'b1;
            end else if (write_strobe && address == `REG_IRQ_STATUS &&
                         write_data[`IRQ_DONE_BIT]) begin
                irq_status <= 1'b0;
            end
        end
    end

    // Level interrupt from a flop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask) && enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port

    // Received word right-aligned: low total_bits of the shift register
    function automatic logic [31:0] rx_aligned(input logic [31:0] w, input logic [5:0] n);
        logic [31:0] m;
        m = (n == 6'h20) ? 32'hFFFF_FFFF : ((32'h0000_0001 << n) - 32'h0000_0001);
        return w & m;
    endfunction : rx_aligned

    // Read data valid only in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            read_data <= `WORD_RESET;
        end else if (read_strobe) begin
            case (address)
                `REG_CONTROL: read_data <= {busy, 14'h0000, control};
                `REG_DATA: read_data <= rx_aligned(shift_word, total_bits);
                `REG_IRQ_STATUS: read_data <= {31'h0000_0000, irq_status};
                `REG_IRQ_MASK: read_data <= {31'h0000_0000, irq_mask};
                default: read_data <= `WORD_RESET;
            endcase
        end else begin
            read_data <= `WORD_RESET;
        end
    end

endmodule : spi_host_controller

/* src/spi_host_defs.svh */
`ifndef SPI_HOST_DEFS_SVH
`define SPI_HOST_DEFS_SVH

// Register word offsets (byte addresses on the plain port)
`define REG_CONTROL 4'h0
`define REG_DATA 4'h4
`define REG_IRQ_STATUS 4'h8
`define REG_IRQ_MASK 4'hC

// Control register fields
`define CTRL_SELECT_LO 0
`define CTRL_SELECT_HI 7
`define CTRL_ENABLE 8
`define CTRL_PHASE 9
`define CTRL_DIV_LO 10
`define CTRL_DIV_HI 12
`define CTRL_SIZE_LO 13
`define CTRL_SIZE_HI 14
`define CTRL_POLARITY 15
`define CTRL_FAST 16
`define CTRL_BUSY 31
`define CTRL_WRITABLE_HI 16

// Interrupt status bit of the transfer-done event
`define IRQ_DONE_BIT 0

// Reset values
`define CONTROL_RESET 17'h0_0000
`define WORD_RESET 32'h0000_0000

// Prescaler divisors for clock_divider_select 0..7
`define DIV_0 13'h0002
`define DIV_1 13'h0004
`define DIV_2 13'h0008
`define DIV_3 13'h0040
`define DIV_4 13'h0080
`define DIV_5 13'h0400
`define DIV_6 13'h0800
`define DIV_7 13'h1000

`endif

/* src/spi_host_pkg.sv */
package spi_host_pkg;

    // Transfer word length encoding of word_length_select
    typedef enum logic [1:0] {
        LEN_8,
        LEN_16,
        LEN_24,
        LEN_32
    } word_length_t;

    // Shift engine states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FIRST_HALF,
        ST_SECOND_HALF
    } shift_state_t;

endpackage : spi_host_pkg

/* src/spi_tick_gen.sv */
`timescale 1ns/100ps
`include "spi_host_defs.svh"

// Half-period tick generator for the serial clock
module spi_tick_gen #(
    parameter int DIV_WIDTH = 13
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic fast_clock_bit,
    input wire logic [2:0] clock_divider_select,
    output logic tick
);
    logic [DIV_WIDTH-1:0] count;

    initial begin
        if (DIV_WIDTH < 13) begin
            $error("DIV_WIDTH must hold the largest divisor");
        end
    end

    // Map the 3-bit select onto its divisor
    function automatic logic [DIV_WIDTH-1:0] divisor(input logic [2:0] sel);
        logic [12:0] d;
        d = `DIV_0;
        case (sel)
            3'h0: d = `DIV_0;
            3'h1: d = `DIV_1;
            3'h2: d = `DIV_2;
            3'h3: d = `DIV_3;
            3'h4: d = `DIV_4;
            3'h5: d = `DIV_5;
            3'h6: d = `DIV_6;
            default: d = `DIV_7;
        endcase
        return DIV_WIDTH'(d);
    endfunction : divisor

    // One tick each divisor cycles, so a full clock takes two divisors
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
            tick <= 1'b0;
        end else if (!run) begin
            count <= '0;
            tick <= 1'b0;
        end else if (fast_clock_bit) begin
            count <= '0;
            tick <= 1'b1;
        end else if (count >= divisor(clock_divider_select) - 1'b1) begin
            count <= '0;
            tick <= 1'b1;
        end else begin
            count <= count + 1'b1;
            tick <= 1'b0;
        end
    end

endmodule : spi_tick_gen

/* verification/spi_host_controller_properties.sv */
`timescale 1ns/100ps
module spi_host_controller_properties (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [3:0] address,
    input wire logic [31:0] write_data,
    input wire logic write_strobe,
    input wire logic read_strobe,
    input wire logic [31:0] read_data,
    input wire logic serial_clock,
    input wire logic serial_data_out,
    input wire logic serial_data_in,
    input wire logic [7:0] select_n,
    input wire logic irq
);
    localparam logic [12:0] DV [8] = '{13'h0002, 13'h0004, 13'h0008, 13'h0040,
        13'h0080, 13'h0400, 13'h0800, 13'h1000};
    logic [31:0] ctl;
    logic [15:0] since;
    logic [12:0] gap;
    logic sck_q;
    wire cw = write_strobe && address == 4'h0;
    wire moved = serial_clock != sck_q;
    wire [12:0] half = ctl[16] ? 13'h0001 : DV[ctl[12:10]];

    ////////////////////////////////////////////////////////////////
    // Last control word and its age; age covers the output latency
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctl <= 32'h0000_0000;
            since <= 16'h0000;
        end else if (cw) begin
            ctl <= write_data;
            since <= 16'h0000;
        end else if (since != 16'hFFFF) begin
            since <= since + 16'h0001;
        end
    end

    // Cycles the serial clock has held its level
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sck_q <= 1'b0;
            gap <= 13'h0000;
        end else begin
            sck_q <= serial_clock;
            if (moved) begin
                gap <= 13'h0001;
            end else if (gap != 13'h1FFF) begin
                gap <= gap + 13'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_sel_follow;
        since > 1 |-> select_n == ~ctl[7:0];
    endproperty
    a_sel_follow: assert property (p_sel_follow)
        else $error("select lines differ from control");
    property p_sel_hold;
        $changed(select_n) |-> $past(cw) || $past(cw, 2);
    endproperty
    a_sel_hold: assert property (p_sel_hold)
        else $error("select lines moved without control write");
    property p_idle;
        since > 1 && !ctl[8] |-> serial_clock == ctl[15];
    endproperty
    a_idle: assert property (p_idle)
        else $error("serial clock not idle while disabled");
    property p_no_irq;
        since > 1 && !ctl[8] |-> !irq;
    endproperty
    a_no_irq: assert property (p_no_irq)
        else $error("interrupt while disabled");
    // Config must have stood for the whole half period being judged
    property p_half;
        moved && ctl[8] && since > gap |-> gap >= half;
    endproperty
    a_half: assert property (p_half)
        else $error("serial clock half period too short");
    property p_start;
        write_strobe && address == 4'h4 && ctl[8] && ctl[16] && since > 0
            |-> ##[1:6] serial_clock != ctl[15];
    endproperty
    a_start: assert property (p_start)
        else $error("data write did not start a transfer");
    property p_sample;
        moved && (serial_clock ^ ctl[15] ^ ctl[9]) && ctl[8] && since > gap
            |-> $stable(serial_data_out);
    endproperty
    a_sample: assert property (p_sample)
        else $error("data out moved on sampling edge");
    property p_mask;
        write_strobe && address == 4'hC && !write_data[0] |-> ##2 !irq;
    endproperty
    a_mask: assert property (p_mask)
        else $error("masked interrupt still high");
endmodule : spi_host_controller_properties

bind spi_host_controller spi_host_controller_properties u_props (.clk(clk),
    .reset_n(reset_n), .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
    .serial_clock(serial_clock), .serial_data_out(serial_data_out),
    .serial_data_in(serial_data_in), .select_n(select_n), .irq(irq));

/* verification/spi_peer_model.sv */
`timescale 1ns/100ps
// Peripheral in clock mode 0: samples on rise, launches on fall
module spi_peer_model (
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic [31:0] reply,
    input wire logic [5:0] len,
    output logic miso,
    output logic [31:0] rx
);
    int k = 0;
    logic drv = 1'h0;
    initial rx = 32'h0000_0000;

    // A new select restarts the word
    always @(negedge cs_n) k = 0;
    // Host bits arrive most significant first
    always @(posedge sclk) begin
        if (!cs_n) begin
            rx = {rx[30:0], mosi};
        end
    end
    // Wraps so words may follow back to back under one select
    always @(negedge sclk) begin
        if (!cs_n) begin
            k = (k + 1) % len;
        end
    end
    always @* begin
        if (!cs_n) begin
            drv = reply[len - 1 - k];
        end
    end
    // Deselected: inverse of the last bit, so stale data never matches
    assign miso = cs_n ? ~drv : drv;
endmodule : spi_peer_model

/* verification/spi_host_controller_tb.sv */
`timescale 1ns/100ps
module spi_host_controller_tb;
    logic clk = 1'h0;
    logic reset_n = 1'h0;
    logic [3:0] address = 4'h0;
    logic [31:0] write_data = 32'h0000_0000;
    logic write_strobe = 1'h0;
    logic read_strobe = 1'h0;
    logic [31:0] read_data, got, prx;
    logic serial_clock, serial_data_out, serial_data_in, irq;
    logic [7:0] select_n;
    logic [31:0] reply = 32'h0000_0000;
    logic [5:0] len = 6'h08;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    int dv [8] = '{2, 4, 8, 64, 128, 1024, 2048, 4096};

    always #50 clk = ~clk;

    spi_host_controller u_dut (.clk(clk), .reset_n(reset_n), .address(address),
        .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
        .read_data(read_data), .serial_clock(serial_clock),
        .serial_data_out(serial_data_out), .serial_data_in(serial_data_in),
        .select_n(select_n), .irq(irq));
    spi_peer_model u_peer (.sclk(serial_clock), .cs_n(select_n[0]), .mosi(serial_data_out),
        .reply(reply), .len(len), .miso(serial_data_in), .rx(prx));

    ////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("mismatches %0d of %0d checks", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        address <= a;
        write_data <= d;
        write_strobe <= 1'h1;
        @(posedge clk);
        write_strobe <= 1'h0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        address <= a;
        read_strobe <= 1'h1;
        @(posedge clk);
        read_strobe <= 1'h0;
        #10 got = read_data;
    endtask : rd

    task automatic tog(output int c);
        logic p;
        p = serial_clock;
        c = 0;
        while (serial_clock === p && c < 9000) begin
            @(posedge clk);
            #1;
            c++;
        end
    endtask : tog

    ////////////////////////////////////////////////////////////////
    task automatic t_lines;
        for (int i = 0; i < 8; i++) begin
            wr(4'h0, 32'(8'h01 << i) | 32'h0000_8000);
            wr(4'h4, 32'h0000_00FF);
            repeat (3) @(posedge clk);
            #1;
            chk("select", {24'h00_0000, ~(8'h01 << i)}, {24'h00_0000, select_n});
            chk("idle clock", 32'h1, {31'h0, serial_clock});
        end
        rd(4'h8);
        chk("status off", 32'h0, got);
        rd(4'h0);
        chk("control", 32'h0000_8080, got);
        rd(4'h2);
        chk("unmapped", 32'h0, got);
    endtask : t_lines

    // High garbage in tx proves only the low bits leave
    task automatic t_xfer(input logic [1:0] sz, input logic [31:0] tx, input logic [31:0] rp);
        int n;
        logic [31:0] m;
        n = 8 * (int'(sz) + 1);
        m = 32'((64'h1 << n) - 64'h1);
        len <= 6'(n);
        reply <= rp;
        // Drop polarity while deselected so the peer never sees a clock edge at select
        wr(4'h0, 32'h0000_0000);
        wr(4'h0, {15'h0000, 2'h0, sz, 3'h2, 2'h1, 8'h01});
        wr(4'h4, tx);
        rd(4'h0);
        chk("busy set", 32'h1, {31'h0, got[31]});
        n = 0;
        while (got[31] !== 1'h0 && n < 3000) begin
            rd(4'h0);
            n++;
        end
        rd(4'h4);
        chk("rx word", rp & m, got & m);
        chk("tx word", tx & m, prx & m);
        chk("irq done", 32'h1, {31'h0, irq});
        wr(4'hC, 32'h0);
        wr(4'h8, 32'h1);
        wr(4'hC, 32'h1);
        repeat (2) @(posedge clk);
        #1;
        chk("irq cleared", 32'h0, {31'h0, irq});
    endtask : t_xfer

    // Index 8 selects the fast bit; each run is aborted mid-word
    task automatic t_rate(input int s);
        int c;
        // Upper runs also set phase 1, which must not change the rate
        wr(4'h0, (s == 8 ? 32'h0001_0100 : 32'h0000_0100 | (32'(s) << 10))
            | (s > 4 ? 32'h0000_0200 : 32'h0000_0000));
        wr(4'h4, 32'h0000_00A5);
        tog(c);
        tog(c);
        chk("half period", s == 8 ? 1 : dv[s], c);
        wr(4'h0, 32'h0000_0000);
        rd(4'h0);
        chk("aborted", 32'h0, {31'h0, got[31]});
        chk("idle after abort", 32'h0, {31'h0, serial_clock});
    endtask : t_rate

    ////////////////////////////////////////////////////////////////
    // Ceiling well above the slowest divider runs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            end_of_test;
        end
    end

    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'h1;
        repeat (3) @(posedge clk);
        #1;
        chk("reset selects", 32'h0000_00FF, {24'h00_0000, select_n});
        rd(4'h0);
        chk("reset control", 32'h0, got);
        t_lines;
        wr(4'hC, 32'h1);
        t_xfer(2'h0, 32'hDEAD_BEA5, 32'h0000_003C);
        t_xfer(2'h1, 32'h1234_8001, 32'h0000_F00F);
        t_xfer(2'h2, 32'hFF5A_C381, 32'h00A5_5A01);
        t_xfer(2'h3, 32'h8000_0001, 32'h7FFF_FFFE);
        for (int s = 0; s < 9; s++) begin
            t_rate(s);
        end
        end_of_test;
    end
endmodule : spi_host_controller_tb
